/* File: rtl/rcd_pkg.sv */
// Constants, types and opcode table of the radio command decoder
package rcd_pkg;

    // Opcodes
    localparam logic [7:0] OP_REG_STORE = 8'h18;
    localparam logic [7:0] OP_REG_FETCH = 8'h19;
    localparam logic [7:0] OP_BUF_STORE = 8'h1a;
    localparam logic [7:0] OP_BUF_FETCH = 8'h1b;
    localparam logic [7:0] OP_LOW_POWER = 8'h84;
    localparam logic [7:0] OP_IDLE = 8'h80;
    localparam logic [7:0] OP_TRANSMIT = 8'h83;
    localparam logic [7:0] OP_RECEIVE = 8'h82;
    localparam logic [7:0] OP_CYCLIC = 8'h94;
    localparam logic [7:0] OP_KIND_WR = 8'h8a;
    localparam logic [7:0] OP_KIND_RD = 8'h03;
    localparam logic [7:0] OP_FREQ = 8'h86;
    localparam logic [7:0] OP_LEVEL = 8'h8e;
    localparam logic [7:0] OP_DETECT = 8'h88;
    localparam logic [7:0] OP_BUF_START = 8'h8f;
    localparam logic [7:0] OP_MOD = 8'h8b;
    localparam logic [7:0] OP_FRAME = 8'h8c;
    localparam logic [7:0] OP_RBUF_INFO = 8'h17;
    localparam logic [7:0] OP_ROUTING = 8'h8d;
    localparam logic [7:0] OP_FLAGS_RD = 8'h15;
    localparam logic [7:0] OP_CLEAR = 8'h97;
    localparam logic [7:0] OP_AUTO_SYNTH = 8'h9e;
    localparam logic [7:0] OP_ROLE = 8'ha3;
    localparam logic [7:0] OP_ENHANCED = 8'h9a;

    // Parameter byte counts
    localparam logic [3:0] PLEN_NONE = 4'h0;
    localparam logic [3:0] PLEN_ONE = 4'h1;
    localparam logic [3:0] PLEN_TWO = 4'h2;
    localparam logic [3:0] PLEN_THREE = 4'h3;
    localparam logic [3:0] PLEN_CYCLIC = 4'h6;
    localparam logic [3:0] PLEN_FRAME = 4'h7;
    localparam logic [3:0] PLEN_ROUTING = 4'h8;
    localparam logic [3:0] PLEN_UNKNOWN = 4'hf;

    // Option byte encodings
    localparam logic [7:0] OPT_OFF = 8'h00;
    localparam logic [7:0] OPT_ON = 8'h01;

    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;

    // Response buffer depth
    localparam int RSP_DEPTH = 2;

    typedef enum logic [1:0] {
        PH_IDLE  = 2'b00,
        PH_PARAM = 2'b01,
        PH_DATA  = 2'b10,
        PH_SKIP  = 2'b11
    } rcd_phase_e;

    // Settings held for the radio core
    typedef struct packed {
        logic [7:0] low_power_cfg;
        logic [7:0] idle_cfg;
        logic [7:0] tx_step_size;
        logic [15:0] tx_step_count;
        logic [7:0] rx_step_size;
        logic [15:0] rx_step_count;
        logic [7:0] listen_step_size;
        logic [15:0] listen_step_count;
        logic [7:0] doze_step_size;
        logic [15:0] doze_step_count;
        logic [7:0] frame_kind;
        logic [23:0] carrier_freq_word;
        logic [7:0] output_power;
        logic [7:0] power_ramp_setting;
        logic [7:0] detect_symbol_count;
        logic [7:0] send_start_offset;
        logic [7:0] recv_start_offset;
        logic [23:0] mod_params;
        logic [55:0] frame_params;
        logic [15:0] event_enable_mask;
        logic [15:0] pin1_route_mask;
        logic [15:0] pin2_route_mask;
        logic [15:0] pin3_route_mask;
        logic auto_synth_hold;
        logic distance_initiator;
        logic enhanced_distance;
    } rcd_cfg_s;

    // One-cycle mode change requests
    typedef struct packed {
        logic enter_low_power;
        logic enter_idle;
        logic begin_transmit;
        logic begin_receive;
        logic cyclic_listen;
    } rcd_go_s;

    // Register space and data buffer access strobes
    typedef struct packed {
        logic sel_buf;
        logic [15:0] addr;
        logic [7:0] wdata;
        logic we;
        logic re;
    } rcd_mem_s;

    typedef struct packed {
        rcd_phase_e phase;
        logic [7:0] opcode;
        logic [3:0] cnt;
        logic [63:0] par;
        logic [7:0] idx;
        logic [15:0] cursor;
        rcd_mem_s mem;
        logic rd_wait;
        rcd_cfg_s cfg;
        rcd_go_s go;
        logic [15:0] flags;
        logic [2:0] pins;
    } rcd_state_s;

    typedef struct packed {
        logic [RSP_DEPTH-1:0][7:0] slot;
        logic wp;
        logic rp;
        logic [1:0] cnt;
    } rcd_fifo_s;

endpackage : rcd_pkg

/* File: rtl/rcd_buf2.sv */
// Two-entry response byte buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module rcd_buf2
    import rcd_pkg::*;
(
    input wire logic core_clk, // Core clock
    input wire logic rstn, // Async reset, active low
    input wire logic in_valid, // Byte offered
    input wire logic [7:0] in_data, // Byte to store
    output logic in_ready, // Room for a byte
    output logic out_valid, // Byte available
    output logic [7:0] out_data, // Oldest byte
    input wire logic out_ready // Receiver takes byte
);
    rcd_fifo_s q_r;
    rcd_fifo_s q_nxt;
    logic push;
    logic pop;

    // Handshakes straight from the occupancy count
    assign in_ready = (q_r.cnt != 2'(RSP_DEPTH));
    assign out_valid = (q_r.cnt != 2'h0);
    assign out_data = q_r.slot[q_r.rp];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // Pointer and count update; full stalls the filler, nothing is dropped
    always_comb begin
        q_nxt = q_r;
        if (push) begin
            q_nxt.slot[q_r.wp] = in_data;
            q_nxt.wp = ~q_r.wp;
        end
        if (pop) begin
            q_nxt.rp = ~q_r.rp;
        end
        case ({push, pop})
            2'b10: q_nxt.cnt = q_r.cnt + 2'h1;
            2'b01: q_nxt.cnt = q_r.cnt - 2'h1;
            default: q_nxt.cnt = q_r.cnt;
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end
endmodule // rcd_buf2
`default_nettype wire

/* File: rtl/rcd_decoder.sv */
// Opcode decoder: parameter capture, settings, memory access, event flags
`timescale 1ns/1ps
`default_nettype none
module rcd_decoder
    import rcd_pkg::*;
(
    input wire logic core_clk, // Core clock, 250 MHz
    input wire logic rstn, // Async reset, active low
    input wire logic cmd_valid, // Host byte offered
    input wire logic cmd_first, // Byte opens a transaction
    input wire logic [7:0] cmd_data, // Host byte
    output logic cmd_ready, // Decoder takes the byte
    output logic rsp_valid, // Result byte available
    output logic [7:0] rsp_data, // Result byte
    input wire logic rsp_ready, // Host side takes result
    output rcd_mem_s mem_req, // Register/buffer access
    input wire logic [7:0] mem_rdata, // Read data, cycle after re
    input wire logic [15:0] evt_src, // Event pulses from radio core
    input wire logic [7:0] recv_payload_len, // Last received length
    input wire logic [7:0] recv_payload_start, // Last payload start offset
    output rcd_cfg_s cfg, // Held settings
    output rcd_go_s go, // Mode change pulses
    output logic [15:0] evt_flags, // Latched event flags
    output logic [2:0] evt_pin // Routed event pins
);
    rcd_state_s s_r;
    rcd_state_s s_nxt;
    logic accept;
    logic buf_in_ready;
    logic push;
    logic [7:0] push_data;
    logic commit;
    logic [63:0] pnew;
    logic [15:0] clr;
    logic [3:0] plen_in;
    logic [15:0] cursor_inc;

    // Parameter count per opcode; unknown opcodes are marked
    function automatic logic [3:0] plen_of(input logic [7:0] op);
        case (op)
            OP_REG_STORE, OP_REG_FETCH: plen_of = PLEN_TWO;
            OP_BUF_STORE, OP_BUF_FETCH: plen_of = PLEN_ONE;
            OP_LOW_POWER, OP_IDLE, OP_KIND_WR: plen_of = PLEN_ONE;
            OP_DETECT, OP_AUTO_SYNTH, OP_ROLE, OP_ENHANCED: plen_of = PLEN_ONE;
            OP_TRANSMIT, OP_RECEIVE: plen_of = PLEN_THREE;
            OP_CYCLIC: plen_of = PLEN_CYCLIC;
            OP_FREQ, OP_MOD: plen_of = PLEN_THREE;
            OP_LEVEL, OP_BUF_START, OP_CLEAR: plen_of = PLEN_TWO;
            OP_FRAME: plen_of = PLEN_FRAME;
            OP_ROUTING: plen_of = PLEN_ROUTING;
            OP_KIND_RD, OP_RBUF_INFO, OP_FLAGS_RD: plen_of = PLEN_NONE;
            default: plen_of = PLEN_UNKNOWN;
        endcase
    endfunction

    // Hold the host while a fetch is in flight, so the read byte always finds room
    assign cmd_ready = buf_in_ready & ~s_r.mem.re & ~s_r.rd_wait;
    assign accept = cmd_valid & cmd_ready;
    assign plen_in = plen_of(cmd_data);
    // Buffer offsets wrap inside the 256-byte buffer
    assign cursor_inc = s_r.mem.sel_buf ? {8'h00, 8'(s_r.cursor[7:0] + 8'h01)}
                                        : 16'(s_r.cursor + 16'h0001);

    // Next-state logic for the whole decoder
    always_comb begin
        s_nxt = s_r;
        s_nxt.go = '0;
        s_nxt.mem.we = 1'b0;
        s_nxt.mem.re = 1'b0;
        s_nxt.rd_wait = s_r.mem.re;
        push = 1'b0;
        push_data = RST_BYTE;
        commit = 1'b0;
        clr = RST_WORD;
        pnew = {s_r.par[55:0], cmd_data};
        // Fetched byte lands one cycle after the read strobe
        if (s_r.rd_wait) begin
            push = 1'b1;
            push_data = mem_rdata;
        end
        if (accept && cmd_first) begin
            // New opcode; anything half-collected is dropped
            s_nxt.opcode = cmd_data;
            s_nxt.cnt = 4'h0;
            s_nxt.par = '0;
            s_nxt.idx = 8'h00;
            if (plen_in == PLEN_UNKNOWN) begin
                s_nxt.phase = PH_SKIP;
            end else if (plen_in == PLEN_NONE) begin
                s_nxt.phase = PH_DATA;
            end else begin
                s_nxt.phase = PH_PARAM;
            end
        end else if (accept) begin
            case (s_r.phase)
                PH_PARAM: begin
                    s_nxt.par = pnew;
                    s_nxt.cnt = 4'(s_r.cnt + 4'h1);
                    if (4'(s_r.cnt + 4'h1) == plen_of(s_r.opcode)) begin
                        commit = 1'b1;
                        s_nxt.phase = PH_DATA;
                    end
                end
                PH_DATA: begin
                    s_nxt.idx = 8'(s_r.idx + 8'h01);
                    case (s_r.opcode)
                        OP_REG_STORE, OP_BUF_STORE: begin
                            s_nxt.mem.we = 1'b1;
                            s_nxt.mem.addr = s_r.cursor;
                            s_nxt.mem.wdata = cmd_data;
                            s_nxt.cursor = cursor_inc;
                        end
                        OP_REG_FETCH, OP_BUF_FETCH: begin
                            s_nxt.mem.re = 1'b1;
                            s_nxt.mem.addr = s_r.cursor;
                            s_nxt.cursor = cursor_inc;
                        end
                        OP_KIND_RD: begin
                            push = 1'b1;
                            push_data = (s_r.idx == 8'h00) ? s_r.cfg.frame_kind
                                                           : RST_BYTE;
                        end
                        OP_RBUF_INFO: begin
                            push = 1'b1;
                            case (s_r.idx)
                                8'h00: push_data = recv_payload_len;
                                8'h01: push_data = recv_payload_start;
                                default: push_data = RST_BYTE;
                            endcase
                        end
                        OP_FLAGS_RD: begin
                            push = 1'b1;
                            case (s_r.idx)
                                8'h00: push_data = s_r.flags[15:8];
                                8'h01: push_data = s_r.flags[7:0];
                                default: push_data = RST_BYTE;
                            endcase
                        end
                        default: begin
                            // Surplus bytes of a fixed command are ignored
                            s_nxt.idx = s_r.idx;
                        end
                    endcase
                end
                default: begin
                    // Idle or skipping an unknown opcode: no state changes
                    s_nxt.phase = s_r.phase;
                end
            endcase
        end
        // Apply a completed parameter list
        if (commit) begin
            case (s_r.opcode)
                OP_REG_STORE, OP_REG_FETCH: begin
                    s_nxt.cursor = pnew[15:0];
                    s_nxt.mem.sel_buf = 1'b0;
                end
                OP_BUF_STORE, OP_BUF_FETCH: begin
                    s_nxt.cursor = {8'h00, pnew[7:0]};
                    s_nxt.mem.sel_buf = 1'b1;
                end
                OP_LOW_POWER: begin
                    s_nxt.cfg.low_power_cfg = pnew[7:0];
                    s_nxt.go.enter_low_power = 1'b1;
                end
                OP_IDLE: begin
                    s_nxt.cfg.idle_cfg = pnew[7:0];
                    s_nxt.go.enter_idle = 1'b1;
                end
                OP_TRANSMIT: begin
                    s_nxt.cfg.tx_step_size = pnew[23:16];
                    s_nxt.cfg.tx_step_count = pnew[15:0];
                    s_nxt.go.begin_transmit = 1'b1;
                end
                OP_RECEIVE: begin
                    s_nxt.cfg.rx_step_size = pnew[23:16];
                    s_nxt.cfg.rx_step_count = pnew[15:0];
                    s_nxt.go.begin_receive = 1'b1;
                end
                OP_CYCLIC: begin
                    s_nxt.cfg.listen_step_size = pnew[47:40];
                    s_nxt.cfg.listen_step_count = pnew[39:24];
                    s_nxt.cfg.doze_step_size = pnew[23:16];
                    s_nxt.cfg.doze_step_count = pnew[15:0];
                    s_nxt.go.cyclic_listen = 1'b1;
                end
                OP_KIND_WR: s_nxt.cfg.frame_kind = pnew[7:0];
                OP_FREQ: s_nxt.cfg.carrier_freq_word = pnew[23:0];
                OP_LEVEL: begin
                    s_nxt.cfg.output_power = pnew[15:8];
                    s_nxt.cfg.power_ramp_setting = pnew[7:0];
                end
                OP_DETECT: s_nxt.cfg.detect_symbol_count = pnew[7:0];
                OP_BUF_START: begin
                    s_nxt.cfg.send_start_offset = pnew[15:8];
                    s_nxt.cfg.recv_start_offset = pnew[7:0];
                end
                OP_MOD: s_nxt.cfg.mod_params = pnew[23:0];
                OP_FRAME: s_nxt.cfg.frame_params = pnew[55:0];
                OP_ROUTING: begin
                    s_nxt.cfg.event_enable_mask = pnew[63:48];
                    s_nxt.cfg.pin1_route_mask = pnew[47:32];
                    s_nxt.cfg.pin2_route_mask = pnew[31:16];
                    s_nxt.cfg.pin3_route_mask = pnew[15:0];
                end
                OP_CLEAR: clr = pnew[15:0];
                // Option bytes other than the two legal codes keep the old setting
                OP_AUTO_SYNTH: begin
                    if (pnew[7:0] == OPT_ON || pnew[7:0] == OPT_OFF) begin
                        s_nxt.cfg.auto_synth_hold = (pnew[7:0] == OPT_ON);
                    end
                end
                OP_ROLE: begin
                    if (pnew[7:0] == OPT_ON || pnew[7:0] == OPT_OFF) begin
                        s_nxt.cfg.distance_initiator = (pnew[7:0] == OPT_ON);
                    end
                end
                OP_ENHANCED: begin
                    if (pnew[7:0] == OPT_ON || pnew[7:0] == OPT_OFF) begin
                        s_nxt.cfg.enhanced_distance = (pnew[7:0] == OPT_ON);
                    end
                end
                default: s_nxt.cfg = s_r.cfg;
            endcase
        end
        // Enabled events set flags; a set in the clearing cycle survives
        s_nxt.flags = (s_r.flags & ~clr) | (evt_src & s_r.cfg.event_enable_mask);
        // Pins follow the new flags and masks in the same cycle they land
        s_nxt.pins[0] = |(s_nxt.flags & s_nxt.cfg.event_enable_mask
                          & s_nxt.cfg.pin1_route_mask);
        s_nxt.pins[1] = |(s_nxt.flags & s_nxt.cfg.event_enable_mask
                          & s_nxt.cfg.pin2_route_mask);
        s_nxt.pins[2] = |(s_nxt.flags & s_nxt.cfg.event_enable_mask
                          & s_nxt.cfg.pin3_route_mask);
    end

    // State register
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Result bytes pass a small buffer so a stalled host loses nothing
    rcd_buf2 u_rsp (
        .core_clk(core_clk),
        .rstn(rstn),
        .in_valid(push),
        .in_data(push_data),
        .in_ready(buf_in_ready),
        .out_valid(rsp_valid),
        .out_data(rsp_data),
        .out_ready(rsp_ready)
    );

    assign mem_req = s_r.mem;
    assign cfg = s_r.cfg;
    assign go = s_r.go;
    assign evt_flags = s_r.flags;
    assign evt_pin = s_r.pins;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    AST_OPCODE_LATCH: assert property (
        accept && cmd_first |=> s_r.opcode == $past(cmd_data))
        else $error("opcode not captured");

    AST_REG_STORE: assert property (
        accept && !cmd_first && s_r.phase == PH_DATA && s_r.opcode == OP_REG_STORE
        |=> mem_req.we && !mem_req.sel_buf && mem_req.wdata == $past(cmd_data)
            && mem_req.addr == $past(s_r.cursor))
        else $error("register store strobe wrong");

    AST_FETCH_RETURN: assert property (
        mem_req.re |=> push && push_data == mem_rdata && !cmd_ready)
        else $error("fetched byte not returned");

    AST_UNKNOWN_SKIP: assert property (
        accept && cmd_first && plen_in == PLEN_UNKNOWN
        |=> s_r.phase == PH_SKIP && $stable(cfg) && !mem_req.we)
        else $error("unknown opcode not skipped");

    AST_CLEAR_FLAGS: assert property (
        clr != RST_WORD |=> (evt_flags & $past(clr) & ~$past(evt_src)) == RST_WORD)
        else $error("cleared flag still set");

    AST_PIN_ROUTE: assert property (
        evt_pin[0] == |(evt_flags & cfg.event_enable_mask & cfg.pin1_route_mask)
        && evt_pin[2] == |(evt_flags & cfg.event_enable_mask & cfg.pin3_route_mask))
        else $error("event pin not routed");

    AST_AUTO_SYNTH: assert property (
        commit && s_r.opcode == OP_AUTO_SYNTH && pnew[7:0] == OPT_ON
        |=> cfg.auto_synth_hold)
        else $error("auto synth not enabled");

    AST_FREQ_WORD: assert property (
        commit && s_r.opcode == OP_FREQ
        |=> cfg.carrier_freq_word == $past(pnew[23:0]))
        else $error("frequency word wrong");

    AST_ROUTING: assert property (
        commit && s_r.opcode == OP_ROUTING
        |=> cfg.event_enable_mask == $past(pnew[63:48])
            && cfg.pin3_route_mask == $past(pnew[15:0]))
        else $error("routing masks wrong");

    AST_KIND_READ: assert property (
        accept && !cmd_first && s_r.phase == PH_DATA && s_r.opcode == OP_KIND_RD
        && s_r.idx == 8'h00 |-> push && push_data == cfg.frame_kind)
        else $error("frame kind not returned");

    AST_LOW_POWER: assert property (
        commit && s_r.opcode == OP_LOW_POWER
        |=> go.enter_low_power && cfg.low_power_cfg == $past(pnew[7:0]) ##1 !go.enter_low_power)
        else $error("low power entry wrong");

    // Enabled events must land even when a clear hits the same bit
    AST_FLAG_SET: assert property (
        (evt_src & cfg.event_enable_mask) != RST_WORD
        |=> (evt_flags & $past(evt_src & cfg.event_enable_mask))
            == $past(evt_src & cfg.event_enable_mask))
        else $error("enabled event lost");

    AST_PIN2_ROUTE: assert property (
        evt_pin[1] == |(evt_flags & cfg.event_enable_mask & cfg.pin2_route_mask))
        else $error("event pin two not routed");

    AST_TRANSMIT_GO: assert property (
        commit && s_r.opcode == OP_TRANSMIT
        |=> go.begin_transmit && cfg.tx_step_size == $past(pnew[23:16])
            && cfg.tx_step_count == $past(pnew[15:0]))
        else $error("transmit entry wrong");

    AST_CYCLIC_GO: assert property (
        commit && s_r.opcode == OP_CYCLIC
        |=> go.cyclic_listen && cfg.listen_step_count == $past(pnew[39:24])
            && cfg.doze_step_count == $past(pnew[15:0]))
        else $error("cyclic listen entry wrong");

    // Option bytes beyond the two legal codes must not disturb any setting
    AST_OPTION_IGNORED: assert property (
        commit && pnew[7:0] > OPT_ON && (s_r.opcode == OP_AUTO_SYNTH
        || s_r.opcode == OP_ROLE || s_r.opcode == OP_ENHANCED)
        |=> $stable(cfg))
        else $error("illegal option byte applied");
endmodule // rcd_decoder
`default_nettype wire

/* File: verif/rcd_mem_model.sv */
// Behavioural register space and data buffer facing the decoder
`timescale 1ns/1ps
`default_nettype none
module rcd_mem_model
    import rcd_pkg::*;
(
    input wire logic core_clk, // Core clock
    input wire rcd_mem_s mem_req, // Access strobes from decoder
    output var logic [7:0] mem_rdata // Read data, cycle after re
);
    // Register space and data buffer kept apart, so a wrong select reads the wrong half
    logic [7:0] mem_r [0:511];
    initial mem_rdata = 8'h00;
    // Inverted junk outside reads so a stale byte is never mistaken for data
    always @(posedge core_clk) begin
        if (mem_req.we) begin
            mem_r[{mem_req.sel_buf, mem_req.addr[7:0]}] <= mem_req.wdata;
        end
        mem_rdata <= mem_req.re ? mem_r[{mem_req.sel_buf, mem_req.addr[7:0]}]
                                : ~mem_rdata;
    end
endmodule // rcd_mem_model
`default_nettype wire

/* File: verif/radio_command_opcode_decoder_tb.sv */
// Self-checking bench for the command decoder
`timescale 1ns/1ps
`default_nettype none
module radio_command_opcode_decoder_tb;
    import rcd_pkg::*;
    logic core_clk = 0, rstn = 0, cmd_valid = 0, cmd_first = 0, rsp_ready = 0;
    logic [7:0] cmd_data = 8'h00, len = 8'h2c, start = 8'h40;
    logic [15:0] evt_src = 16'h0000;
    logic cmd_ready, rsp_valid;
    logic [7:0] rsp_data, mem_rdata;
    rcd_mem_s mem_req;
    rcd_cfg_s cfg;
    rcd_go_s go, go_seen;
    logic [15:0] evt_flags;
    logic [2:0] evt_pin;
    int n_fail = 0, checked = 0, cyc = 0;
    rcd_decoder u_dut (.core_clk(core_clk), .rstn(rstn), .cmd_valid(cmd_valid),
        .cmd_first(cmd_first), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ready(rsp_ready),
        .mem_req(mem_req), .mem_rdata(mem_rdata), .evt_src(evt_src),
        .recv_payload_len(len), .recv_payload_start(start), .cfg(cfg), .go(go),
        .evt_flags(evt_flags), .evt_pin(evt_pin));
    rcd_mem_model u_mem (.core_clk(core_clk), .mem_req(mem_req), .mem_rdata(mem_rdata));
    // 250 MHz clock
    initial forever #2 core_clk = ~core_clk;
    // Sticky record of mode change pulses; they last one cycle only
    always @(posedge core_clk) go_seen <= rstn ? (go_seen | go) : '0;
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Whole transaction; valid held until the last byte is taken
    task automatic cmd(input logic [7:0] b[$]);
        foreach (b[i]) begin
            @(negedge core_clk);
            cmd_valid = 1;
            cmd_first = (i == 0);
            cmd_data = b[i];
            while (cmd_ready !== 1'b1) @(negedge core_clk);
            @(posedge core_clk);
        end
        @(negedge core_clk);
        cmd_valid = 0;
        repeat (3) @(negedge core_clk);
    endtask
    task automatic rd(input logic [7:0] e);
        int i;
        i = 0;
        @(negedge core_clk);
        while (rsp_valid !== 1'b1 && i < 20) begin
            @(negedge core_clk);
            i++;
        end
        rsp_ready = 1;
        chk("rsp_data", {56'h0, e}, {56'h0, rsp_data});
        @(posedge core_clk);
        @(negedge core_clk);
        rsp_ready = 0;
    endtask
    task automatic conclude();
        $display("Comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Hang guard, far above the few hundred cycles the tests need
    always @(posedge core_clk) begin
        cyc++;
        if (cyc > 5000) begin
            n_fail++;
            conclude();
        end
    end
    initial begin
        repeat (10) @(negedge core_clk);
        rstn = 1;
        cmd('{8'h18, 8'h12, 8'h34, 8'h5a});
        cmd('{8'h19, 8'h12, 8'h34, 8'h00});
        rd(8'h5a);
        cmd('{8'h1a, 8'h07, 8'ha5});
        cmd('{8'h1b, 8'h07, 8'h00});
        rd(8'ha5);
        $display("memory access test done");
        cmd('{8'h83, 8'h02, 8'hab, 8'hcd});
        chk("tx_step", 64'h02abcd, {cfg.tx_step_size, cfg.tx_step_count});
        cmd('{8'h86, 8'h11, 8'h22, 8'h33});
        chk("carrier_freq_word", 64'h112233, cfg.carrier_freq_word);
        cmd('{8'h9e, 8'h01});
        chk("auto_synth_hold", 64'h1, cfg.auto_synth_hold);
        cmd('{8'hc0, 8'h83, 8'hff, 8'hff});
        chk("tx_step_unknown", 64'h02abcd, {cfg.tx_step_size, cfg.tx_step_count});
        cmd('{8'h84, 8'h05});
        chk("low_power_cfg", 64'h05, cfg.low_power_cfg);
        cmd('{8'h80, 8'h01});
        chk("idle_cfg", 64'h01, cfg.idle_cfg);
        cmd('{8'h82, 8'h03, 8'h12, 8'h34});
        chk("rx_step", 64'h031234, {cfg.rx_step_size, cfg.rx_step_count});
        cmd('{8'h94, 8'h01, 8'h00, 8'h10, 8'h02, 8'h00, 8'h20});
        chk("listen", 64'h010010, {cfg.listen_step_size, cfg.listen_step_count});
        chk("doze", 64'h020020, {cfg.doze_step_size, cfg.doze_step_count});
        chk("go_seen", 64'h1f, go_seen);
        cmd('{8'h8e, 8'h1f, 8'h02});
        chk("output_level", 64'h1f02, {cfg.output_power, cfg.power_ramp_setting});
        cmd('{8'h88, 8'h04});
        chk("detect_symbol_count", 64'h04, cfg.detect_symbol_count);
        cmd('{8'h8f, 8'h80, 8'h00});
        chk("buf_start", 64'h8000, {cfg.send_start_offset, cfg.recv_start_offset});
        cmd('{8'h8b, 8'haa, 8'hbb, 8'hcc});
        chk("mod_params", 64'haabbcc, cfg.mod_params);
        cmd('{8'h8c, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07});
        chk("frame_params", 64'h01020304050607, cfg.frame_params);
        cmd('{8'ha3, 8'h01});
        chk("distance_initiator", 64'h1, cfg.distance_initiator);
        cmd('{8'h9a, 8'h01});
        cmd('{8'h9a, 8'h02});
        chk("enhanced_distance", 64'h1, cfg.enhanced_distance);
        $display("settings test done");
        cmd('{8'h8a, 8'h01});
        cmd('{8'h03, 8'h00});
        rd(8'h01);
        cmd('{8'h17, 8'h00, 8'h00});
        rd(8'h2c);
        rd(8'h40);
        $display("status read test done");
        cmd('{8'h8d, 8'h00, 8'h03, 8'h00, 8'h01, 8'h00, 8'h02, 8'h00, 8'h00});
        evt_src = 16'h0003;
        @(negedge core_clk);
        evt_src = 16'h0000;
        repeat (2) @(negedge core_clk);
        chk("evt_flags", 64'h3, evt_flags);
        chk("evt_pin", 64'h3, evt_pin);
        cmd('{8'h97, 8'h00, 8'h01});
        chk("evt_flags_clr", 64'h2, evt_flags);
        chk("evt_pin_clr", 64'h2, evt_pin);
        cmd('{8'h15, 8'h00, 8'h00});
        rd(8'h00);
        rd(8'h02);
        $display("event test done");
        conclude();
    end
endmodule // radio_command_opcode_decoder_tb
`default_nettype wire
